/* spc_pkg.sv */
// Shared constants and types for the segment privilege checker.
// Assumes a single 200 MHz core clock and synchronous active-low reset.
package spc_pkg;

	// ----------------------------------------
	// Privilege encoding
	// ----------------------------------------
	localparam logic [1:0] LEVEL_MOST  = 2'h0;
	localparam logic [1:0] LEVEL_LEAST = 2'h3;
	localparam int         NUM_STACK_LEVELS = 3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic       RESET_PROTECT   = 1'h0;
	localparam logic [1:0] RESET_LEVEL     = 2'h0;
	localparam logic [1:0] RESET_IO_THRESH = 2'h0;

	// ----------------------------------------
	// Request kinds from the execution pipeline
	// ----------------------------------------
	typedef enum logic [3:0] {
		SPC_REQ_DATA     = 4'h0,
		SPC_REQ_CODE     = 4'h1,
		SPC_REQ_SENS_IO  = 4'h2,
		SPC_REQ_SENS_INT = 4'h3,
		SPC_REQ_FAR_JUMP = 4'h4,
		SPC_REQ_FAR_CALL = 4'h5,
		SPC_REQ_PROC_RET = 4'h6,
		SPC_REQ_TRAP_RET = 4'h7,
		SPC_REQ_INTR     = 4'h8
	} spc_req_t;

	// Descriptor kinds presented with a transfer
	typedef enum logic [2:0] {
		SPC_DESC_CODE      = 3'h0,
		SPC_DESC_CALL_GATE = 3'h1,
		SPC_DESC_INT_GATE  = 3'h2,
		SPC_DESC_TRAP_GATE = 3'h3,
		SPC_DESC_TASK_BLK  = 3'h4,
		SPC_DESC_TASK_GATE = 3'h5,
		SPC_DESC_DATA      = 3'h6
	} spc_desc_t;

	// Table a descriptor came from
	typedef enum logic [1:0] {
		SPC_TBL_GLOBAL = 2'h0,
		SPC_TBL_LOCAL  = 2'h1,
		SPC_TBL_INTR   = 2'h2
	} spc_tbl_t;

	// Checker sequencer states
	typedef enum logic [3:0] {
		SPC_ST_IDLE   = 4'b0001,
		SPC_ST_BITMAP = 4'b0010,
		SPC_ST_STACK  = 4'b0100,
		SPC_ST_DONE   = 4'b1000
	} spc_state_t;

endpackage

/* spc_stack_store.sv */
// Small memory holding the per-level stack selector and pointer copies.
// Assumes one clock; read data are registered and appear one cycle after rd_en.
`timescale 1ns/100ps

module spc_stack_store #(
	parameter int DEPTH = 3,
	parameter int WIDTH = 48,
	parameter int AW    = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en && (int'(wr_addr) < DEPTH)) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
		end
	end

endmodule

/* spc_checker.sv */
// Segment privilege checker: access, I/O and control-transfer checks.
// Assumes the pipeline holds a request until done, and that a bitmap lookup
// answers with a single-cycle bitmap_valid after bitmap_req.
`timescale 1ns/100ps

module spc_checker #(
	parameter int SEL_W = 16,
	parameter int PTR_W = 32
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// Mode and flags
	input  wire logic                 protect_enable_bit,
	input  wire logic                 flags_write,
	input  wire logic [1:0]           flags_io_threshold,
	input  wire logic                 nested_task_flag,
	input  wire logic                 task_block_32,
	// Request from the pipeline
	input  wire logic                 req_valid,
	input  wire spc_pkg::spc_req_t    req_kind,
	input  wire logic [1:0]           requested_level,
	input  wire logic [1:0]           descriptor_level,
	input  wire spc_pkg::spc_desc_t   desc_kind,
	input  wire spc_pkg::spc_tbl_t    desc_table,
	input  wire logic [1:0]           target_level,
	input  wire logic [SEL_W-1:0]     code_selector,
	// Stack values from the task block and for the outer stack
	input  wire logic                 tsb_stack_we,
	input  wire logic [1:0]           tsb_stack_level,
	input  wire logic [SEL_W-1:0]     tsb_stack_selector,
	input  wire logic [PTR_W-1:0]     tsb_stack_pointer,
	input  wire logic [SEL_W-1:0]     cur_stack_selector,
	input  wire logic [PTR_W-1:0]     cur_stack_pointer,
	input  wire logic [SEL_W-1:0]     saved_stack_selector,
	input  wire logic [PTR_W-1:0]     saved_stack_pointer,
	// Port permission bitmap lookup
	output logic                      bitmap_req,
	input  wire logic                 bitmap_valid,
	input  wire logic                 bitmap_deny,
	// Results
	output logic                      done,
	output logic                      grant,
	output logic                      gp_fault,
	output logic                      protected_mode,
	output logic [1:0]                current_level,
	output logic [1:0]                effective_level,
	output logic [1:0]                io_privilege_threshold,
	output logic [SEL_W-1:0]          code_selector_reg,
	output logic                      stack_load,
	output logic                      stack_push_old,
	output logic [SEL_W-1:0]          stack_selector,
	output logic [PTR_W-1:0]          stack_pointer
);

	localparam int SW = SEL_W + PTR_W;

	// ----------------------------------------
	// Privilege arithmetic
	// ----------------------------------------
	logic [1:0] cur_eff;
	logic [1:0] next_eff;

	always_comb begin
		cur_eff  = protected_mode ? current_level : spc_pkg::LEVEL_MOST;
		next_eff = (requested_level > cur_eff) ? requested_level : cur_eff;
	end

	// ----------------------------------------
	// Decisions for the request held at the input
	// ----------------------------------------
	logic access_ok;
	logic io_direct;
	logic type_ok;
	logic gate_ok;
	logic is_gate;
	logic level_change;
	logic is_transfer;
	logic task_switch;

	always_comb begin
		// Data and code segment accesses compare the effective level
		access_ok = (next_eff <= descriptor_level);
		// Sensitive operations against the threshold
		io_direct = (cur_eff <= io_privilege_threshold);
		is_gate = (desc_kind == spc_pkg::SPC_DESC_CALL_GATE) ||
		          (desc_kind == spc_pkg::SPC_DESC_INT_GATE)  ||
		          (desc_kind == spc_pkg::SPC_DESC_TRAP_GATE) ||
		          (desc_kind == spc_pkg::SPC_DESC_TASK_GATE);
		gate_ok = !is_gate || (next_eff <= descriptor_level);
		task_switch = (desc_kind == spc_pkg::SPC_DESC_TASK_BLK) ||
		              (desc_kind == spc_pkg::SPC_DESC_TASK_GATE);
		is_transfer = (req_kind == spc_pkg::SPC_REQ_FAR_JUMP) ||
		              (req_kind == spc_pkg::SPC_REQ_FAR_CALL) ||
		              (req_kind == spc_pkg::SPC_REQ_PROC_RET) ||
		              (req_kind == spc_pkg::SPC_REQ_TRAP_RET) ||
		              (req_kind == spc_pkg::SPC_REQ_INTR);
		level_change = protected_mode && !task_switch && (target_level != current_level);
		type_ok = 1'b0;
		case (req_kind)
			spc_pkg::SPC_REQ_FAR_JUMP: begin
				type_ok = (desc_kind == spc_pkg::SPC_DESC_CODE && target_level == cur_eff &&
				           desc_table != spc_pkg::SPC_TBL_INTR) ||
				          (desc_kind == spc_pkg::SPC_DESC_TASK_BLK &&
				           desc_table == spc_pkg::SPC_TBL_GLOBAL) ||
				          (desc_kind == spc_pkg::SPC_DESC_TASK_GATE &&
				           desc_table != spc_pkg::SPC_TBL_INTR);
			end
			spc_pkg::SPC_REQ_FAR_CALL: begin
				type_ok = (desc_kind == spc_pkg::SPC_DESC_CODE && target_level == cur_eff &&
				           desc_table != spc_pkg::SPC_TBL_INTR) ||
				          (desc_kind == spc_pkg::SPC_DESC_CALL_GATE &&
				           target_level <= cur_eff &&
				           desc_table != spc_pkg::SPC_TBL_INTR) ||
				          (desc_kind == spc_pkg::SPC_DESC_TASK_BLK &&
				           desc_table == spc_pkg::SPC_TBL_GLOBAL) ||
				          (desc_kind == spc_pkg::SPC_DESC_TASK_GATE &&
				           desc_table != spc_pkg::SPC_TBL_INTR);
			end
			spc_pkg::SPC_REQ_PROC_RET: begin
				type_ok = !nested_task_flag && desc_kind == spc_pkg::SPC_DESC_CODE &&
				          target_level >= cur_eff &&
				          desc_table != spc_pkg::SPC_TBL_INTR;
			end
			spc_pkg::SPC_REQ_TRAP_RET: begin
				if (nested_task_flag) begin
					type_ok = desc_kind == spc_pkg::SPC_DESC_TASK_GATE &&
					          desc_table == spc_pkg::SPC_TBL_INTR;
				end else begin
					type_ok = desc_kind == spc_pkg::SPC_DESC_CODE &&
					          target_level >= cur_eff &&
					          desc_table != spc_pkg::SPC_TBL_INTR;
				end
			end
			spc_pkg::SPC_REQ_INTR: begin
				type_ok = desc_table == spc_pkg::SPC_TBL_INTR &&
				          (desc_kind == spc_pkg::SPC_DESC_INT_GATE  ||
				           desc_kind == spc_pkg::SPC_DESC_TRAP_GATE ||
				           desc_kind == spc_pkg::SPC_DESC_TASK_GATE);
			end
			default: begin
				type_ok = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	spc_pkg::spc_state_t state;
	logic                verdict_ok;
	logic                pend_stack;
	logic                pend_restore;
	logic [1:0]          pend_level;
	logic [SEL_W-1:0]    pend_selector;

	// Real mode has no protection, so every request is granted there
	logic instant_ok;
	always_comb begin
		instant_ok = 1'b0;
		case (req_kind)
			spc_pkg::SPC_REQ_DATA:     instant_ok = access_ok;
			spc_pkg::SPC_REQ_CODE:     instant_ok = access_ok;
			spc_pkg::SPC_REQ_SENS_IO:  instant_ok = io_direct;
			spc_pkg::SPC_REQ_SENS_INT: instant_ok = io_direct;
			default:                   instant_ok = type_ok && gate_ok;
		endcase
		if (!protected_mode) begin
			instant_ok = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state        <= spc_pkg::SPC_ST_IDLE;
			verdict_ok   <= 1'b0;
			pend_stack   <= 1'b0;
			pend_restore <= 1'b0;
			pend_level   <= spc_pkg::RESET_LEVEL;
			pend_selector <= '0;
		end else begin
			case (state)
				spc_pkg::SPC_ST_IDLE: begin
					if (req_valid) begin
						pend_level    <= target_level;
						pend_selector <= code_selector;
						pend_stack    <= 1'b0;
						pend_restore  <= 1'b0;
						if (protected_mode && req_kind == spc_pkg::SPC_REQ_SENS_IO &&
						    !io_direct && task_block_32) begin
							state <= spc_pkg::SPC_ST_BITMAP;
						end else if (instant_ok && is_transfer && level_change) begin
							// Outward returns restore, inward transfers load new stack
							pend_restore <= (target_level > current_level);
							pend_stack   <= 1'b1;
							verdict_ok   <= 1'b1;
							state        <= spc_pkg::SPC_ST_STACK;
						end else begin
							verdict_ok <= instant_ok;
							state      <= spc_pkg::SPC_ST_DONE;
						end
					end
				end
				spc_pkg::SPC_ST_BITMAP: begin
					if (bitmap_valid) begin
						verdict_ok <= !bitmap_deny;
						state      <= spc_pkg::SPC_ST_DONE;
					end
				end
				spc_pkg::SPC_ST_STACK: begin
					state <= spc_pkg::SPC_ST_DONE;
				end
				spc_pkg::SPC_ST_DONE: begin
					state <= spc_pkg::SPC_ST_IDLE;
				end
				default: begin
					state <= spc_pkg::SPC_ST_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		bitmap_req = (state == spc_pkg::SPC_ST_BITMAP);
		done       = (state == spc_pkg::SPC_ST_DONE);
		grant      = done && verdict_ok;
		gp_fault   = done && !verdict_ok;
	end

	// ----------------------------------------
	// Architectural state
	// ----------------------------------------
	logic commit;
	assign commit = done && verdict_ok;

	// Mode follows the protect enable bit; reset gives real mode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			protected_mode <= spc_pkg::RESET_PROTECT;
		end else begin
			protected_mode <= protect_enable_bit;
		end
	end

	// Flags writes change the threshold only from level 0
	always_ff @(posedge clk) begin
		if (!resetn) begin
			io_privilege_threshold <= spc_pkg::RESET_IO_THRESH;
		end else if (flags_write && cur_eff == spc_pkg::LEVEL_MOST) begin
			io_privilege_threshold <= flags_io_threshold;
		end
	end

	// Level and selector only move on a committed transfer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			current_level     <= spc_pkg::RESET_LEVEL;
			code_selector_reg <= '0;
		end else if (commit && is_transfer) begin
			code_selector_reg <= pend_selector;
			current_level     <= protected_mode ? pend_level : spc_pkg::LEVEL_MOST;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			effective_level <= spc_pkg::RESET_LEVEL;
		end else if (req_valid && state == spc_pkg::SPC_ST_IDLE) begin
			effective_level <= next_eff;
		end
	end

	// ----------------------------------------
	// Stack switching
	// ----------------------------------------
	logic [SW-1:0] stk_rd;

	spc_stack_store #(
		.DEPTH (spc_pkg::NUM_STACK_LEVELS),
		.WIDTH (SW),
		.AW    (2)
	) u_stack_store (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (tsb_stack_we),
		.wr_addr (tsb_stack_level),
		.wr_data ({tsb_stack_selector, tsb_stack_pointer}),
		.rd_en   (req_valid && state == spc_pkg::SPC_ST_IDLE),
		.rd_addr (target_level),
		.rd_data (stk_rd)
	);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			stack_load     <= 1'b0;
			stack_push_old <= 1'b0;
			stack_selector <= '0;
			stack_pointer  <= '0;
		end else begin
			stack_load     <= 1'b0;
			stack_push_old <= 1'b0;
			if (state == spc_pkg::SPC_ST_STACK && pend_stack) begin
				stack_load <= 1'b1;
				if (pend_restore) begin
					stack_selector <= saved_stack_selector;
					stack_pointer  <= saved_stack_pointer;
				end else begin
					stack_selector <= stk_rd[SW-1:PTR_W];
					stack_pointer  <= stk_rd[PTR_W-1:0];
					stack_push_old <= 1'b1;
				end
			end
		end
	end

	// Outer stack values are kept by the pipeline for the push
	logic unused_cur;
	assign unused_cur = ^{cur_stack_selector, cur_stack_pointer};

endmodule

/* spc_checker_asserts.sv */
// Concurrent checks on the segment privilege checker ports.
// Assumes one clock, synchronous active-low reset; bound to spc_checker.
`timescale 1ns/100ps

module spc_checker_asserts (
	// Clock and reset
	input wire logic              clk,
	input wire logic              resetn,
	// Inputs watched
	input wire logic              protect_enable_bit,
	input wire logic              flags_write,
	input wire logic              task_block_32,
	input wire logic              req_valid,
	input wire spc_pkg::spc_req_t req_kind,
	input wire logic [1:0]        requested_level,
	input wire logic [1:0]        descriptor_level,
	input wire logic              bitmap_valid,
	input wire logic              bitmap_deny,
	// Outputs watched
	input wire logic              bitmap_req,
	input wire logic              done,
	input wire logic              grant,
	input wire logic              gp_fault,
	input wire logic              protected_mode,
	input wire logic [1:0]        current_level,
	input wire logic [1:0]        io_privilege_threshold
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_reset_real_mode: assert property ($rose(resetn) |->
		!protected_mode && current_level == 2'h0)
		else $error("not in real mode at level 0 after reset");
	a_mode_follows_pe: assert property ($past(resetn) |->
		protected_mode == $past(protect_enable_bit))
		else $error("protected mode does not follow enable bit");
	a_outcome_one_hot: assert property (done |-> grant ^ gp_fault)
		else $error("done without exactly one outcome");
	a_outcome_with_done: assert property (!done |-> !grant && !gp_fault)
		else $error("outcome pulse outside done");
	a_real_grants: assert property (done && !protected_mode |-> grant)
		else $error("fault raised in real mode");
	a_data_level: assert property (done && protected_mode &&
		req_kind == spc_pkg::SPC_REQ_DATA |->
		grant == ((requested_level > current_level ? requested_level : current_level)
		<= descriptor_level))
		else $error("data access outcome wrong for levels");
	a_fault_keeps_level: assert property (done && gp_fault |=> $stable(current_level))
		else $error("level changed on fault");
	a_access_keeps_level: assert property (done && req_kind inside {
		spc_pkg::SPC_REQ_DATA, spc_pkg::SPC_REQ_CODE, spc_pkg::SPC_REQ_SENS_IO,
		spc_pkg::SPC_REQ_SENS_INT} |=> $stable(current_level))
		else $error("level changed by a non-transfer");
	a_thresh_stable: assert property (!flags_write |=> $stable(io_privilege_threshold))
		else $error("threshold changed without a write");
	a_sens_allowed: assert property (done && current_level <= io_privilege_threshold &&
		req_kind inside {spc_pkg::SPC_REQ_SENS_IO, spc_pkg::SPC_REQ_SENS_INT} |-> grant)
		else $error("sensitive op refused within threshold");
	a_sens_other_fault: assert property (done && protected_mode &&
		req_kind == spc_pkg::SPC_REQ_SENS_INT &&
		current_level > io_privilege_threshold |-> gp_fault)
		else $error("sensitive op allowed above threshold");
	a_bitmap_answer: assert property (bitmap_req && bitmap_valid |=>
		done && grant == !$past(bitmap_deny))
		else $error("bitmap answer not applied next cycle");
	a_bitmap_32_only: assert property (bitmap_req |-> task_block_32)
		else $error("bitmap consulted for a 16-bit block");
	a_done_bounded: assert property ($rose(req_valid) |-> ##[1:40] done)
		else $error("request never completed");
endmodule

bind spc_checker spc_checker_asserts i_asserts (.clk, .resetn, .protect_enable_bit,
	.flags_write, .task_block_32, .req_valid, .req_kind, .requested_level,
	.descriptor_level, .bitmap_valid, .bitmap_deny, .bitmap_req, .done, .grant,
	.gp_fault, .protected_mode, .current_level, .io_privilege_threshold);

/* spc_bitmap_model.sv */
// Port permission bitmap lookup answering the checker.
// Assumes bitmap_req stays high until the answer edge.
`timescale 1ns/100ps

module spc_bitmap_model #(
	parameter int DLY = 2
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic bitmap_req,
	input  wire logic deny_set,
	output logic      bitmap_valid,
	output logic      bitmap_deny
);
	logic [3:0] cnt;
	logic       tog;

	// Deny toggles outside the answer so a stale value never looks valid
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tog          <= 1'b0;
			cnt          <= 4'h0;
			bitmap_valid <= 1'b0;
		end else begin
			tog          <= ~tog;
			bitmap_valid <= 1'b0;
			if (bitmap_req && !bitmap_valid) begin
				if (cnt == 4'(DLY)) begin
					bitmap_valid <= 1'b1;
					cnt          <= 4'h0;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end else begin
				cnt <= 4'h0;
			end
		end
	end

	assign bitmap_deny = bitmap_valid ? deny_set : tog;
endmodule

/* spc_checker_tb_top.sv */
// Self-checking bench for the segment privilege checker.
// Assumes a 200 MHz clock and a request that is held high until done.
`timescale 1ns/100ps

module spc_checker_tb_top;
	logic clk, resetn, pe, fw, ntf, tb32, rv, sw, deny;
	logic [1:0] fthr, rl, dl, tl, sl_lvl, cl, thr, el;
	spc_pkg::spc_req_t  rk;
	spc_pkg::spc_desc_t dk;
	spc_pkg::spc_tbl_t  tbl;
	logic [15:0] ssel, csel, csr;
	logic [31:0] sptr, tptr;
	logic bm_req, bm_val, bm_deny, done, grant, gpf, pm, sld, spo, c_sl, c_sp;
	int n_mismatch, check_count;

	// Short names for the descriptor kinds and tables used below
	localparam spc_pkg::spc_desc_t DDAT = spc_pkg::SPC_DESC_DATA;
	localparam spc_pkg::spc_desc_t DCOD = spc_pkg::SPC_DESC_CODE;
	localparam spc_pkg::spc_desc_t DCG  = spc_pkg::SPC_DESC_CALL_GATE;
	localparam spc_pkg::spc_desc_t DIG  = spc_pkg::SPC_DESC_INT_GATE;
	localparam spc_pkg::spc_desc_t DTB  = spc_pkg::SPC_DESC_TASK_BLK;
	localparam spc_pkg::spc_desc_t DTG  = spc_pkg::SPC_DESC_TASK_GATE;
	localparam spc_pkg::spc_tbl_t  GLB  = spc_pkg::SPC_TBL_GLOBAL;
	localparam spc_pkg::spc_tbl_t  LOC  = spc_pkg::SPC_TBL_LOCAL;
	localparam spc_pkg::spc_tbl_t  ITB  = spc_pkg::SPC_TBL_INTR;

	spc_checker i_dut (.clk, .resetn, .protect_enable_bit(pe), .flags_write(fw),
		.flags_io_threshold(fthr), .nested_task_flag(ntf), .task_block_32(tb32),
		.req_valid(rv), .req_kind(rk), .requested_level(rl), .descriptor_level(dl),
		.desc_kind(dk), .desc_table(tbl), .target_level(tl), .code_selector(csel),
		.tsb_stack_we(sw), .tsb_stack_level(sl_lvl), .tsb_stack_selector(16'h00a0),
		.tsb_stack_pointer(tptr), .cur_stack_selector(16'h0), .cur_stack_pointer(32'h0),
		.saved_stack_selector(16'h00b0), .saved_stack_pointer(32'h2000),
		.bitmap_req(bm_req), .bitmap_valid(bm_val), .bitmap_deny(bm_deny), .done,
		.grant, .gp_fault(gpf), .protected_mode(pm), .current_level(cl),
		.effective_level(el), .io_privilege_threshold(thr), .code_selector_reg(csr),
		.stack_load(sld), .stack_push_old(spo), .stack_selector(ssel), .stack_pointer(sptr));

	spc_bitmap_model i_bitmap (.clk, .resetn, .bitmap_req(bm_req), .deny_set(deny),
		.bitmap_valid(bm_val), .bitmap_deny(bm_deny));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	// One request held until done; outcome taken in the done cycle
	task automatic rq(input spc_pkg::spc_req_t k, input int r, d, t,
		input spc_pkg::spc_desc_t dd, input spc_pkg::spc_tbl_t tt, input int eg);
		int n;
		n = 0;
		rk = k;
		rl = 2'(r);
		dl = 2'(d);
		tl = 2'(t);
		dk = dd;
		tbl = tt;
		rv = 1'b1;
		@(negedge clk);
		while (done !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		c_sl = sld;
		c_sp = spo;
		chk("done", 1, done);
		chk("grant", eg, grant);
		chk("gp_fault", eg == 0, gpf);
		step();
		rv = 1'b0;
		step();
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{resetn, pe, fw, ntf, tb32, rv, sw, deny, fthr, rl, dl, tl, sl_lvl} = '0;
		rk = spc_pkg::SPC_REQ_DATA;
		dk = DDAT;
		tbl = GLB;
		csel = 16'h0008;
		tptr = 32'h0;
		n_mismatch = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		step();
		chk("protected_mode", 0, pm);
		chk("current_level", 0, cl);
		rq(spc_pkg::SPC_REQ_DATA, 3, 0, 0, DDAT, GLB, 1);
		// Tables are taken as set up in real mode, so protection may be switched on
		pe = 1'b1;
		step();
		chk("protected_mode", 1, pm);
		for (int r = 0; r < 4; r++)
			for (int d = 0; d < 4; d++)
				rq(spc_pkg::SPC_REQ_DATA, r, d, 0, DDAT, GLB, r <= d);
		fthr = 2'h1;
		fw = 1'b1;
		step();
		fw = 1'b0;
		step();
		chk("threshold", 1, thr);
		rq(spc_pkg::SPC_REQ_SENS_INT, 0, 0, 0, DDAT, GLB, 1);
		csel = 16'h0018;
		rq(spc_pkg::SPC_REQ_FAR_JUMP, 0, 0, 0, DDAT, GLB, 0);
		chk("code_selector_reg", 0, csr);
		rq(spc_pkg::SPC_REQ_FAR_JUMP, 0, 0, 0, DCOD, LOC, 1);
		chk("code_selector_reg", 16'h0018, csr);
		rq(spc_pkg::SPC_REQ_INTR, 0, 0, 0, DIG, ITB, 1);
		rq(spc_pkg::SPC_REQ_FAR_CALL, 0, 0, 0, DTB, GLB, 1);
		// Outward return to level 3 restores the saved outer stack
		rq(spc_pkg::SPC_REQ_PROC_RET, 3, 3, 3, DCOD, GLB, 1);
		chk("stack_load", 1, c_sl);
		chk("stack_push_old", 0, c_sp);
		chk("stack_selector", 16'h00b0, ssel);
		chk("stack_pointer", 32'h2000, sptr);
		chk("current_level", 3, cl);
		rq(spc_pkg::SPC_REQ_DATA, 0, 2, 0, DDAT, GLB, 0);
		chk("effective_level", 3, el);
		rq(spc_pkg::SPC_REQ_DATA, 0, 3, 0, DDAT, GLB, 1);
		rq(spc_pkg::SPC_REQ_CODE, 0, 2, 0, DCOD, GLB, 0);
		ntf = 1'b1;
		rq(spc_pkg::SPC_REQ_TRAP_RET, 3, 3, 3, DCOD, GLB, 0);
		rq(spc_pkg::SPC_REQ_TRAP_RET, 3, 3, 3, DTG, ITB, 1);
		ntf = 1'b0;
		chk("current_level", 3, cl);
		fthr = 2'h3;
		fw = 1'b1;
		step();
		fw = 1'b0;
		step();
		chk("threshold", 1, thr);
		rq(spc_pkg::SPC_REQ_SENS_INT, 3, 3, 3, DDAT, GLB, 0);
		chk("current_level", 3, cl);
		rq(spc_pkg::SPC_REQ_SENS_IO, 3, 3, 3, DDAT, GLB, 0);
		tb32 = 1'b1;
		rq(spc_pkg::SPC_REQ_SENS_IO, 3, 3, 3, DDAT, GLB, 1);
		deny = 1'b1;
		rq(spc_pkg::SPC_REQ_SENS_IO, 3, 3, 3, DDAT, GLB, 0);
		rq(spc_pkg::SPC_REQ_FAR_CALL, 3, 2, 0, DCG, GLB, 0);
		// Inward call through a gate takes the level 0 stack from the task block
		tptr = 32'h1000;
		sw = 1'b1;
		step();
		sw = 1'b0;
		step();
		rq(spc_pkg::SPC_REQ_FAR_CALL, 3, 3, 0, DCG, GLB, 1);
		chk("stack_load", 1, c_sl);
		chk("stack_push_old", 1, c_sp);
		chk("stack_selector", 16'h00a0, ssel);
		chk("stack_pointer", 32'h1000, sptr);
		chk("current_level", 0, cl);
		give_verdict();
	end

	// Whole sequence needs well under a thousand cycles
	initial begin
		#8000;
		n_mismatch++;
		give_verdict();
	end
endmodule
